// ### include/hmp_pkg.sv
/*
 * Package for the host memory port read path: overlay register layout,
 * port bundles, fetch state codes and timing counts.
 * Assumes a single 125 MHz core clock.
 */
package hmp_pkg;

    localparam int          HMP_DATA_W          = 16;
    localparam int          HMP_ADDR_W          = 14;
    // Overlay register word address and short-read-only bit
    localparam logic [13:0] HMP_OVERLAY_ADDR    = 14'h3fe7;
    localparam int          HMP_SRO_BIT         = 14;
    localparam logic [15:0] HMP_OVERLAY_RESET   = 16'h0000;
    localparam logic [15:0] HMP_OVERLAY_WMASK   = 16'hffff;
    // Internal memory read latency in cycles before a fetch completes
    localparam int          HMP_FETCH_CYCLES    = 2;

    typedef enum logic [1:0] {
        HMP_IDLE  = 2'b00,
        HMP_READ  = 2'b01,
        HMP_FETCH = 2'b10
    } hmp_state_t;

    // Host side strobes, all active low
    typedef struct packed {
        logic sel_n;
        logic rd_n;
    } hmp_host_t;

    // Core side overlay register write request
    typedef struct packed {
        logic                  wr;
        logic [HMP_DATA_W-1:0] data;
    } hmp_core_wr_t;

endpackage

// ### design/hmp_read_path.sv
/*
 * Read path of the 16-bit host memory port: previous-word presentation,
 * bus release, acknowledge and next-word fetch, plus the overlay register
 * holding the short-read-only enable.
 * A read shows the word that the fetch before it brought in; the fetch
 * for the next word starts only once the host ends the read, and the
 * acknowledge stays high until that word has landed. Both read modes
 * keep the previous word on the bus for the whole read.
 * Assumes host pins are synchronous to I_CLK and that the address counter
 * and memory live outside; memory answers one word per fetch request.
 * Fetched halves must be stable on I_MEM_LO and I_MEM_HI when the fetch
 * counter expires; overlay writes arrive as one-cycle pulses.
 */
`timescale 1ns/1ps

// How it works
// - Overlay bit 14 selects short-read-only mode
// - Core or host may write that bit
// - Short-read-only disabled after reset
// - Short-read-only holds previous word until end
// - Read start drives previous fetched word
// - Select or strobe high releases bus
// - Program words return as two halves
// - Ack goes high at start, low later
module hmp_read_path
    import hmp_pkg::*;
#(
    parameter int FETCH_CYCLES = HMP_FETCH_CYCLES
) (
    input  wire logic                  I_CLK,
    input  wire logic                  I_RESETN,
    input  wire hmp_host_t             I_HOST,
    input  wire logic                  I_HOST_OVL_WR,
    input  wire logic [HMP_DATA_W-1:0] I_HOST_WDATA,
    input  wire hmp_core_wr_t          I_CORE_OVL,
    input  wire logic                  I_PM_SPACE,
    input  wire logic [HMP_DATA_W-1:0] I_MEM_LO,
    input  wire logic [HMP_DATA_W-1:0] I_MEM_HI,
    output logic                       O_PORT_ACK_N,
    output logic [HMP_DATA_W-1:0]      O_PORT_AD,
    output logic                       O_PORT_AD_OE,
    output logic                       O_MEM_REQ,
    output logic [HMP_DATA_W-1:0]      O_OVERLAY,
    output logic                       O_SRO_MODE,
    output logic                       O_PM_SECOND
);

    // Fetch counter is eight bits wide and must reach one
    if (FETCH_CYCLES < 1 || FETCH_CYCLES > 255) begin : g_bad_fetch
        $error("FETCH_CYCLES out of range");
    end

    // Mode bit must sit inside the overlay word
    if (HMP_SRO_BIT >= HMP_DATA_W) begin : g_bad_sro_bit
        $error("HMP_SRO_BIT outside overlay word");
    end

    // Overlay register
    logic [HMP_DATA_W-1:0] ovl_q, ovl_d;

    // Read sequencing
    hmp_state_t            state_q, state_d;
    logic [7:0]            cnt_q, cnt_d;
    logic                  oe_q, oe_d;
    logic                  ack_n_q, ack_n_d;
    logic                  req_q, req_d;

    // Presented word and program half tracking
    logic [HMP_DATA_W-1:0] data_q, data_d;
    logic                  half_q, half_d;

    // Decoded host and fetch events
    logic                  rd_active;
    logic                  rd_start;
    logic                  rd_end;
    logic                  fetch_done;
    logic                  take_hi;

    assign rd_active  = !I_HOST.sel_n && !I_HOST.rd_n;
    // host starts only with ack low
    assign rd_start   = rd_active && !ack_n_q;
    // select or strobe high ends read
    assign rd_end     = !rd_active;
    // Last count of a fetch
    assign fetch_done = (state_q == HMP_FETCH) && (cnt_q == 8'h01);
    assign take_hi    = I_PM_SPACE && !half_q;

    // Overlay register
    always_comb begin
        ovl_d = ovl_q;
        if (I_CORE_OVL.wr) begin
            ovl_d = I_CORE_OVL.data & HMP_OVERLAY_WMASK;
        end
        if (I_HOST_OVL_WR) begin
            ovl_d = I_HOST_WDATA & HMP_OVERLAY_WMASK;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ovl_q <= HMP_OVERLAY_RESET;
        end else begin
            ovl_q <= ovl_d;
        end
    end

    // Read sequencing
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        oe_d    = oe_q;
        ack_n_d = ack_n_q;
        req_d   = 1'b0;
        unique case (state_q)
            HMP_IDLE: begin
                if (rd_start) begin
                    oe_d    = 1'b1;
                    ack_n_d = 1'b1;
                    state_d = HMP_READ;
                end
            end
            HMP_READ: begin
                if (rd_end) begin
                    oe_d    = 1'b0;
                    req_d   = 1'b1;
                    cnt_d   = 8'(FETCH_CYCLES);
                    state_d = HMP_FETCH;
                end
            end
            HMP_FETCH: begin
                if (fetch_done) begin
                    ack_n_d = 1'b0;
                    state_d = HMP_IDLE;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                // Illegal code: drop the bus and fall back to idle
                oe_d    = 1'b0;
                ack_n_d = 1'b0;
                state_d = HMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_q <= HMP_IDLE;
            cnt_q   <= 8'h00;
            oe_q    <= 1'b0;
            ack_n_q <= 1'b0;
            req_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            oe_q    <= oe_d;
            ack_n_q <= ack_n_d;
            req_q   <= req_d;
        end
    end

    // Only a finished fetch replaces the word, so a read always shows
    // the word fetched after the access before it
    always_comb begin
        data_d = data_q;
        half_d = half_q;
        if (fetch_done) begin
            if (take_hi) begin
                data_d = I_MEM_HI;
                half_d = 1'b1;
            end else begin
                data_d = I_MEM_LO;
                half_d = 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            data_q <= '0;
            half_q <= 1'b0;
        end else begin
            data_q <= data_d;
            half_q <= half_d;
        end
    end

    assign O_SRO_MODE   = ovl_q[HMP_SRO_BIT];
    // word held in data_q for the whole read in either mode
    assign O_PORT_AD    = data_q;
    assign O_PORT_AD_OE = oe_q;
    assign O_PORT_ACK_N = ack_n_q;
    assign O_MEM_REQ    = req_q;
    assign O_OVERLAY    = ovl_q;
    assign O_PM_SECOND  = half_q;

endmodule // hmp_read_path

// ### verif/hmp_read_path_checker.sv
/* Port checker for the host memory port read path.
   Bound to hmp_read_path; sees its ports only. */
`timescale 1ns/1ps
module hmp_read_path_checker
    import hmp_pkg::*;
#(parameter int FETCH_CYCLES = 2) (
    input wire logic         I_CLK,
    input wire logic         I_RESETN,
    input wire hmp_host_t    I_HOST,
    input wire logic         I_HOST_OVL_WR,
    input wire logic [15:0]  I_HOST_WDATA,
    input wire hmp_core_wr_t I_CORE_OVL,
    input wire logic         O_PORT_ACK_N,
    input wire logic [15:0]  O_PORT_AD,
    input wire logic         O_PORT_AD_OE,
    input wire logic         O_MEM_REQ,
    input wire logic [15:0]  O_OVERLAY,
    input wire logic         O_SRO_MODE
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    wire rd_lo = !I_HOST.sel_n && !I_HOST.rd_n;
    sequence s_fetch;
        O_PORT_ACK_N ##FETCH_CYCLES !O_PORT_ACK_N;
    endsequence
    AST_START: assert property (rd_lo && !O_PORT_ACK_N && !O_PORT_AD_OE
        |=> O_PORT_ACK_N && O_PORT_AD_OE) else $error("start ack/oe");
    AST_END: assert property (O_PORT_AD_OE && !rd_lo
        |=> !O_PORT_AD_OE && O_MEM_REQ) else $error("end release");
    AST_HOLD: assert property (O_PORT_AD_OE && rd_lo
        |=> O_PORT_AD_OE && $stable(O_PORT_AD)) else $error("hold word");
    AST_FETCH: assert property (O_MEM_REQ |-> s_fetch)
        else $error("fetch ack");
    AST_BUSY: assert property (O_PORT_ACK_N && !O_PORT_AD_OE
        |=> !O_PORT_AD_OE) else $error("read while busy");
    AST_SRO: assert property (O_SRO_MODE == O_OVERLAY[14])
        else $error("sro bit");
    AST_HWR: assert property (I_HOST_OVL_WR
        |=> O_OVERLAY == $past(I_HOST_WDATA)) else $error("host write");
    AST_CWR: assert property (I_CORE_OVL.wr && !I_HOST_OVL_WR
        |=> O_OVERLAY == $past(I_CORE_OVL.data)) else $error("core write");
endmodule // hmp_read_path_checker

// ### verif/hmp_host_model.sv
/* Host model: performs reads on the port.
   Assumes inputs sampled just after the rising clock edge. */
`timescale 1ns/1ps
module hmp_host_model
    import hmp_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_ack_n,
    input  wire logic        i_oe,
    input  wire logic [15:0] i_ad,
    output hmp_host_t        o_host
);
    initial o_host = '1;
    task automatic rd(output logic [15:0] d);
        int n;
        n = 0;
        while (i_ack_n !== 1'b0 && n < 150) begin
            @(posedge i_clk); #1 n++;
        end
        o_host = '0;
        while (i_oe !== 1'b1 && n < 150) begin
            @(posedge i_clk); #1 n++;
        end
        d = i_ad;
        repeat (2) @(posedge i_clk);
        #1 o_host = '1;
        while (i_ack_n !== 1'b0 && n < 150) begin
            @(posedge i_clk); #1 n++;
        end
        // Lost handshake poisons the word so the caller's compare trips
        if (n >= 150) begin
            d = 'x;
        end
    endtask
endmodule // hmp_host_model

// ### verif/test_host_port_read_path.sv
/* Bench for the read path: reads, overlay writes, program space.
   Assumes a host model and memory halves driven here. */
`timescale 1ns/1ps
`define CHK(n,e,a) n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end
module test_host_port_read_path;
    import hmp_pkg::*;
    logic clk = 0, rstn = 0, hwr = 0, pm = 0;
    logic ack_n, oe, req, sro, pm2;
    logic [15:0] hwd = 0, lo = 0, hi = 0, ad, ovl, d;
    hmp_core_wr_t cw = '0;
    hmp_host_t host;
    int err_count = 0, n_tests = 0, cyc = 0;
    hmp_read_path #(.FETCH_CYCLES(3)) u_hmp_read_path (.I_CLK(clk),
        .I_RESETN(rstn), .I_HOST(host), .I_HOST_OVL_WR(hwr),
        .I_HOST_WDATA(hwd), .I_CORE_OVL(cw), .I_PM_SPACE(pm),
        .I_MEM_LO(lo), .I_MEM_HI(hi), .O_PORT_ACK_N(ack_n), .O_PORT_AD(ad),
        .O_PORT_AD_OE(oe), .O_MEM_REQ(req), .O_OVERLAY(ovl),
        .O_SRO_MODE(sro), .O_PM_SECOND(pm2));
    hmp_host_model u_hmp_host_model (.i_clk(clk), .i_ack_n(ack_n),
        .i_oe(oe), .i_ad(ad), .o_host(host));
    initial forever #4 clk = ~clk;
    task close_out();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rstn = 1;
        lo = 16'h1a2b;
        `CHK("ovl", 16'h0000, ovl)
        u_hmp_host_model.rd(d); `CHK("rd0", 16'h0000, d)
        u_hmp_host_model.rd(d); `CHK("rd1", 16'h1a2b, d)
        lo = 16'h5e6f;
        cw = '{1'b1, 16'h4000};
        @(posedge clk); #1 cw.wr = 0;
        `CHK("sro", 1'b1, sro)
        u_hmp_host_model.rd(d); `CHK("rd2", 16'h1a2b, d)
        u_hmp_host_model.rd(d); `CHK("rd3", 16'h5e6f, d)
        hwr = 1; cw = '{1'b1, 16'hffff};
        @(posedge clk); #1 hwr = 0; cw.wr = 0;
        `CHK("ovl", 16'h0000, ovl)
        pm = 1; hi = 16'h7788;
        u_hmp_host_model.rd(d); `CHK("rd4", 16'h5e6f, d)
        `CHK("pm2", 1'b1, pm2)
        u_hmp_host_model.rd(d); `CHK("rd5", 16'h7788, d)
        `CHK("pm2", 1'b0, pm2)
        u_hmp_host_model.rd(d); `CHK("rd6", 16'h5e6f, d)
        close_out();
    end
endmodule // test_host_port_read_path
bind hmp_read_path hmp_read_path_checker
    #(.FETCH_CYCLES(FETCH_CYCLES)) u_chk (.*);
